// ===== hdl/cptb_buffers.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - six buffers, each transmit or receive
// - buffers inert in legacy mode
// - direction bit one transmit, resets zero
// - full flag blocks reload until cleared
// - accept-all takes any frame, ignores filters
// - remote flag mirrors stored frame type
// - filter index of last admitted frame
// - transmit-complete set on successful send
// - aborted flag set on abort
// - arbitration-lost flag set on loss
// - bus-error flag set on error
// - setting request clears four status flags
// - request self-clears after successful send
// - software clearing request means abort
// - transmit registers locked while pending
// - matching remote request auto-sets request
// - priority orders sending, id untouched
// - id high byte standard or extended
// - id low byte layout, unused read zero
// - extended flag set for extended frames
// - substitute remote bit only when extended
// - id writable in transmit, loaded in receive
module cptb_buffers
  import cptb_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic [cptb_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [cptb_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [cptb_pkg::DATA_W-1:0]        avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          rx_frame_valid,
  input  wire logic                          rx_frame_ok,
  input  wire logic                          rx_filter_pass,
  input  wire logic [cptb_pkg::FILT_W-1:0]   rx_filter_index,
  input  wire logic [cptb_pkg::ID_W-1:0]     rx_frame_id,
  input  wire logic                          rx_frame_ext,
  input  wire logic                          rx_frame_rtr,
  input  wire logic                          rx_frame_srr,
  output logic                               tx_frame_valid,
  input  wire logic                          tx_frame_ready,
  output logic [cptb_pkg::IDX_W-1:0]         tx_frame_index,
  output logic [cptb_pkg::ID_W-1:0]          tx_frame_id,
  output logic                               tx_frame_ext,
  output logic                               tx_abort_request,
  input  wire logic                          tx_sent,
  input  wire logic                          tx_lost_arb,
  input  wire logic                          tx_bus_error
);
  import cptb_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              full;
    logic              accall;
    logic              rtr;
    logic [FILT_W-1:0] filt;
    logic              req;
    logic              auto_remote_reply_en;
    logic [PRIO_W-1:0] prio;
    logic              done;
    logic              abt;
    logic              arb;
    logic              err;
    logic              abort_pend;
    logic [7:0]        idh;
    logic [2:0]        sidl;
    logic              ext;
    logic              srr;
    logic [1:0]        e1716;
    logic [7:0]        eidh;
    logic [7:0]        eidl;
  } cptb_buf_type;

  typedef struct packed {
    cptb_buf_type [NUM_BUFFERS-1:0] bufs;
    logic [NUM_BUFFERS-1:0]         dir;
    logic [MODE_W-1:0]              mode;
    logic                           ack;
    logic [DATA_W-1:0]              rdata;
    logic                           busy;
    logic [IDX_W-1:0]               busy_idx;
    logic                           fr_valid;
    logic [IDX_W-1:0]               fr_idx;
    logic [ID_W-1:0]                fr_id;
    logic                           fr_ext;
  } cptb_state_type;

  cptb_state_type state_reg;
  cptb_state_type state_next;

  function automatic logic [ID_W-1:0] full_id(input cptb_buf_type b);
    if (b.ext)
      full_id = {b.idh, b.sidl, b.e1716, b.eidh, b.eidl};
    else
      full_id = {18'h00000, b.idh, b.sidl};
  endfunction : full_id

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic                  enh;
    logic                  req_on;
    logic                  wr_go;
    logic                  in_buf;
    logic [IDX_W-1:0]      idx;
    logic [2:0]            sub;
    logic [7:0]            wb;
    logic [DATA_W-1:0]     rv;
    logic                  locked;
    logic                  rx_hit;
    logic [IDX_W-1:0]      rx_idx;
    logic                  sel_ok;
    logic [IDX_W-1:0]      sel_idx;
    logic [PRIO_W-1:0]     sel_prio;
    logic [ID_W-1:0]       rid;
    state_next = state_reg;
    enh      = (state_reg.mode == MODE_ENH1) || (state_reg.mode == MODE_ENH2);
    req_on   = avs_read || avs_write;
    wr_go    = avs_write && state_reg.ack && avs_byteenable[0];
    in_buf   = avs_address[BUF_SEL_BIT];
    idx      = avs_address[BUF_IDX_LSB +: IDX_W];
    sub      = avs_address[SUB_LSB +: 3];
    wb       = avs_writedata[7:0];
    rv       = '0;
    locked   = 1'b0;
    rx_hit   = 1'b0;
    rx_idx   = '0;
    sel_ok   = 1'b0;
    sel_idx  = '0;
    sel_prio = '0;
    rid      = '0;

    // ----------------------------------------------------------------
    // bus answer: one wait cycle, read data captured with the ack
    // ----------------------------------------------------------------
    state_next.ack = req_on && !state_reg.ack;
    if (!in_buf)
    begin
      case (avs_address)
        ADDR_MODE:    rv[MODE_W-1:0] = state_reg.mode;
        ADDR_DIR:     rv[DIR_LSB +: NUM_BUFFERS] = state_reg.dir;
        ADDR_TX_STAT: rv[IDX_W+1:0] = {state_reg.busy, state_reg.busy_idx, state_reg.fr_valid};
        default:      rv = '0;
      endcase
    end
    else if (enh && (idx < IDX_W'(NUM_BUFFERS)))
    begin
      case (sub)
        SUB_CTRL:
          if (state_reg.dir[idx])
            rv[7:0] = {state_reg.bufs[idx].done, state_reg.bufs[idx].abt,
                       state_reg.bufs[idx].arb, state_reg.bufs[idx].err,
                       state_reg.bufs[idx].req, state_reg.bufs[idx].auto_remote_reply_en,
                       state_reg.bufs[idx].prio};
          else
            rv[7:0] = {state_reg.bufs[idx].full, state_reg.bufs[idx].accall,
                       state_reg.bufs[idx].rtr, state_reg.bufs[idx].filt};
        SUB_IDH:  rv[7:0] = state_reg.bufs[idx].idh;
        SUB_IDL:  rv[7:0] = {state_reg.bufs[idx].sidl,
                             state_reg.bufs[idx].srr && !state_reg.dir[idx],
                             state_reg.bufs[idx].ext, 1'b0,
                             state_reg.bufs[idx].e1716};
        SUB_EIDH: rv[7:0] = state_reg.bufs[idx].eidh;
        SUB_EIDL: rv[7:0] = state_reg.bufs[idx].eidl;
        default:  rv = '0;
      endcase
    end
    if (req_on && !state_reg.ack)
      state_next.rdata = avs_read ? rv : '0;

    // ----------------------------------------------------------------
    // software writes
    // ----------------------------------------------------------------
    if (wr_go && !in_buf)
    begin
      if (avs_address == ADDR_MODE)
        state_next.mode = wb[MODE_W-1:0];
      if (avs_address == ADDR_DIR)
        state_next.dir = wb[DIR_LSB +: NUM_BUFFERS];
    end
    if (wr_go && in_buf && enh && (idx < IDX_W'(NUM_BUFFERS)))
    begin
      locked = state_reg.bufs[idx].req ||
               (state_reg.busy && (state_reg.busy_idx == idx));
      if (sub == SUB_CTRL)
      begin
        if (state_reg.dir[idx])
        begin
          if (wb[CTRL_REQ] && !state_reg.bufs[idx].req)
          begin
            state_next.bufs[idx].req  = 1'b1;
            state_next.bufs[idx].done = 1'b0;
            state_next.bufs[idx].abt  = 1'b0;
            state_next.bufs[idx].arb  = 1'b0;
            state_next.bufs[idx].err  = 1'b0;
          end
          else if (!wb[CTRL_REQ] && state_reg.bufs[idx].req)
          begin
            // an in-flight frame can only be stopped by the engine
            if (state_reg.busy && (state_reg.busy_idx == idx))
              state_next.bufs[idx].abort_pend = 1'b1;
            else
            begin
              state_next.bufs[idx].req = 1'b0;
              state_next.bufs[idx].abt = 1'b1;
            end
          end
          if (!locked)
          begin
            state_next.bufs[idx].auto_remote_reply_en = wb[CTRL_AUTO_REMOTE_REPLY_EN];
            state_next.bufs[idx].prio  = wb[PRIO_W-1:0];
          end
        end
        else
        begin
          state_next.bufs[idx].accall = wb[CTRL_ACCALL];
          if (!wb[CTRL_FULL])
            state_next.bufs[idx].full = 1'b0;
        end
      end
      else if (state_reg.dir[idx] && !locked)
      begin
        case (sub)
          SUB_IDH:  state_next.bufs[idx].idh = wb;
          SUB_IDL:
          begin
            state_next.bufs[idx].sidl  = wb[IDL_SID_LSB +: 3];
            state_next.bufs[idx].ext   = wb[IDL_EXT];
            state_next.bufs[idx].e1716 = wb[1:0];
          end
          SUB_EIDH: state_next.bufs[idx].eidh = wb;
          SUB_EIDL: state_next.bufs[idx].eidl = wb;
          default:  state_next.bufs[idx].idh = state_reg.bufs[idx].idh;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // receive: lowest open receive buffer takes the frame
    // ----------------------------------------------------------------
    for (int i = NUM_BUFFERS - 1; i >= 0; i--)
    begin
      if (!state_reg.dir[i] && !state_reg.bufs[i].full &&
          (state_reg.bufs[i].accall || (rx_frame_ok && rx_filter_pass)))
      begin
        rx_hit = 1'b1;
        rx_idx = IDX_W'(i);
      end
    end
    if (enh && rx_frame_valid && rx_hit)
    begin
      rid = rx_frame_id;
      state_next.bufs[rx_idx].full = 1'b1;
      state_next.bufs[rx_idx].rtr  = rx_frame_rtr;
      state_next.bufs[rx_idx].filt = rx_filter_index;
      state_next.bufs[rx_idx].ext  = rx_frame_ext;
      state_next.bufs[rx_idx].srr  = rx_frame_ext && rx_frame_srr;
      if (rx_frame_ext)
      begin
        state_next.bufs[rx_idx].idh   = rid[28:21];
        state_next.bufs[rx_idx].sidl  = rid[20:18];
        state_next.bufs[rx_idx].e1716 = rid[17:16];
        state_next.bufs[rx_idx].eidh  = rid[15:8];
        state_next.bufs[rx_idx].eidl  = rid[7:0];
      end
      else
      begin
        state_next.bufs[rx_idx].idh   = rid[10:3];
        state_next.bufs[rx_idx].sidl  = rid[2:0];
        state_next.bufs[rx_idx].e1716 = '0;
        state_next.bufs[rx_idx].eidh  = '0;
        state_next.bufs[rx_idx].eidl  = '0;
      end
    end

    // ----------------------------------------------------------------
    // automatic remote reply
    // ----------------------------------------------------------------
    for (int i = 0; i < NUM_BUFFERS; i++)
    begin
      if (enh && rx_frame_valid && rx_frame_ok && rx_frame_rtr &&
          state_reg.dir[i] && state_reg.bufs[i].auto_remote_reply_en && !state_reg.bufs[i].req &&
          (state_reg.bufs[i].ext == rx_frame_ext) &&
          (full_id(state_reg.bufs[i]) == rx_frame_id))
      begin
        state_next.bufs[i].req  = 1'b1;
        state_next.bufs[i].done = 1'b0;
        state_next.bufs[i].abt  = 1'b0;
        state_next.bufs[i].arb  = 1'b0;
        state_next.bufs[i].err  = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // transmit outcome from the engine; wins over same-cycle writes
    // ----------------------------------------------------------------
    if (state_reg.busy && (tx_sent || tx_lost_arb || tx_bus_error))
    begin
      state_next.busy = 1'b0;
      state_next.bufs[state_reg.busy_idx].abort_pend = 1'b0;
      if (tx_sent)
      begin
        state_next.bufs[state_reg.busy_idx].done = 1'b1;
        state_next.bufs[state_reg.busy_idx].req  = 1'b0;
      end
      else
      begin
        if (tx_lost_arb)
          state_next.bufs[state_reg.busy_idx].arb = 1'b1;
        if (tx_bus_error)
          state_next.bufs[state_reg.busy_idx].err = 1'b1;
        if (state_reg.bufs[state_reg.busy_idx].abort_pend)
        begin
          state_next.bufs[state_reg.busy_idx].abt = 1'b1;
          state_next.bufs[state_reg.busy_idx].req = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // pick next frame: priority, ties to higher index
    // ----------------------------------------------------------------
    for (int i = 0; i < NUM_BUFFERS; i++)
    begin
      if (state_reg.dir[i] && state_reg.bufs[i].req && !state_reg.bufs[i].abort_pend &&
          (!sel_ok || (state_reg.bufs[i].prio >= sel_prio)))
      begin
        sel_ok   = 1'b1;
        sel_idx  = IDX_W'(i);
        sel_prio = state_reg.bufs[i].prio;
      end
    end
    if (state_reg.fr_valid && tx_frame_ready)
    begin
      state_next.busy     = 1'b1;
      state_next.busy_idx = state_reg.fr_idx;
      state_next.fr_valid = 1'b0;
      // offer was one cycle old; an abort in between must reach the engine
      if (!state_reg.bufs[state_reg.fr_idx].req)
        state_next.bufs[state_reg.fr_idx].abort_pend = 1'b1;
    end
    else if (!state_reg.busy)
    begin
      state_next.fr_valid = enh && sel_ok;
      state_next.fr_idx   = sel_idx;
      state_next.fr_id    = full_id(state_reg.bufs[sel_idx]);
      state_next.fr_ext   = state_reg.bufs[sel_idx].ext;
    end
    else
      state_next.fr_valid = 1'b0;

    if (srst)
    begin
      state_next     = '0;
      state_next.dir = DIR_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata     = state_reg.rdata;
  assign avs_waitrequest  = (avs_read || avs_write) && !state_reg.ack;
  assign tx_frame_valid   = state_reg.fr_valid;
  assign tx_frame_index   = state_reg.fr_idx;
  assign tx_frame_id      = state_reg.fr_id;
  assign tx_frame_ext     = state_reg.fr_ext;
  assign tx_abort_request = state_reg.busy && state_reg.bufs[state_reg.busy_idx].abort_pend;

endmodule : cptb_buffers

`default_nettype wire

// ===== hdl/cptb_pkg.sv
package cptb_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_BUFFERS = 6;
  localparam int IDX_W       = 3;
  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 32;
  localparam int ID_W        = 29;
  localparam int FILT_W      = 5;
  localparam int PRIO_W      = 2;
  localparam int MODE_W      = 2;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_MODE    = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_DIR     = 9'h004;
  localparam logic [ADDR_W-1:0] ADDR_TX_STAT = 9'h008;
  localparam int BUF_SEL_BIT = 8;
  localparam int BUF_IDX_LSB = 5;
  localparam int SUB_LSB     = 2;
  localparam logic [2:0] SUB_CTRL = 3'h0;
  localparam logic [2:0] SUB_IDH  = 3'h1;
  localparam logic [2:0] SUB_IDL  = 3'h2;
  localparam logic [2:0] SUB_EIDH = 3'h3;
  localparam logic [2:0] SUB_EIDL = 3'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DIR_LSB       = 2;
  localparam int CTRL_FULL     = 7;
  localparam int CTRL_ACCALL   = 6;
  localparam int CTRL_REQ      = 3;
  localparam int CTRL_AUTO_REMOTE_REPLY_EN    = 2;
  localparam int IDL_SID_LSB   = 5;
  localparam int IDL_EXT       = 3;

  // ----------------------------------------------------------------
  // operating modes and reset values
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_LEGACY = 2'h0;
  localparam logic [MODE_W-1:0] MODE_ENH1   = 2'h1;
  localparam logic [MODE_W-1:0] MODE_ENH2   = 2'h2;
  localparam logic [NUM_BUFFERS-1:0] DIR_RESET = 6'h00;

endpackage : cptb_pkg

// ===== testbench/cptb_buffers_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cptb_buffers_bench;
  import cptb_pkg::*;
  logic              clk, srst, avs_read, avs_write, avs_waitrequest, stall;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable, delay;
  logic              rx_frame_valid, rx_frame_ok, rx_filter_pass, rx_frame_ext, rx_frame_rtr;
  logic              rx_frame_srr, tx_frame_valid, tx_frame_ready, tx_frame_ext;
  logic              tx_abort_request, tx_sent, tx_lost_arb, tx_bus_error;
  logic [FILT_W-1:0] rx_filter_index;
  logic [ID_W-1:0]   rx_frame_id, tx_frame_id, id0, id1, id2;
  logic [IDX_W-1:0]  tx_frame_index;
  logic [1:0]        outcome;
  logic [31:0]       seed;
  logic [7:0]        rd, h4, l4, eh, el;
  int                failures, comparisons, outs;
  logic [IDX_W-1:0]  took_idx[$];
  logic [ID_W:0]     took_id[$];

  cptb_buffers dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_frame_valid, .rx_frame_ok,
    .rx_filter_pass, .rx_filter_index, .rx_frame_id, .rx_frame_ext, .rx_frame_rtr,
    .rx_frame_srr, .tx_frame_valid, .tx_frame_ready, .tx_frame_index, .tx_frame_id,
    .tx_frame_ext, .tx_abort_request, .tx_sent, .tx_lost_arb, .tx_bus_error);
  cptb_engine_model partner (.clk, .srst, .tx_frame_valid, .stall, .outcome, .delay,
    .tx_frame_ready, .tx_sent, .tx_lost_arb, .tx_bus_error);

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (tx_frame_valid && tx_frame_ready)
    begin
      took_idx.push_back(tx_frame_index);
      took_id.push_back({tx_frame_ext, tx_frame_id});
    end
    if (tx_sent || tx_lost_arb || tx_bus_error)
      outs++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [8:0] ba(input int n, input int sub);
    return 9'h100 + 9'(n * 32 + sub * 4);
  endfunction : ba
  function automatic logic [7:0] idh(input logic [28:0] id, input logic e);
    return e ? id[28:21] : id[10:3];
  endfunction : idh
  function automatic logic [7:0] idl(input logic [28:0] id, input logic e, input logic s);
    return e ? {id[20:18], s, 2'h2, id[17:16]} : {id[2:0], 5'h00};
  endfunction : idl
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= 32'(d);
    avs_read <= !wr;
    avs_write <= wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'h0 && ++n < 50);
    rd = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 50)
      failures++;
  endtask : bus
  task automatic rdchk(input string w, input logic [8:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(w, 32'(e), 32'(rd));
  endtask : rdchk
  task automatic rx(input logic [28:0] id, input logic e, r, s, ok, input logic [4:0] f);
    @(posedge clk);
    {rx_frame_id, rx_frame_ext, rx_frame_rtr, rx_frame_srr} <= {id, e, r, s};
    {rx_frame_ok, rx_filter_pass, rx_filter_index, rx_frame_valid} <= {ok, ok, f, 1'h1};
    @(posedge clk);
    rx_frame_valid <= 1'h0;
  endtask : rx
  task automatic settle(input int t, input int o);
    for (int i = 0; i < 400 && (took_idx.size() < t || outs < o); i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk("takes", t, took_idx.size());
  endtask : settle
  task automatic wrap_up;
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial
  begin
    {srst, stall, avs_byteenable, delay, outcome, seed} = {2'h3, 4'h1, 4'h2, 2'h0, 32'hbf4a};
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {rx_frame_valid, rx_frame_ok, rx_filter_pass, rx_filter_index, rx_frame_id} = '0;
    {rx_frame_ext, rx_frame_rtr, rx_frame_srr, outs, failures, comparisons} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    rdchk("dir reset", ADDR_DIR, 8'h00);
    bus(1'h1, ba(0, 0), 8'h40);
    rdchk("legacy ctrl", ba(0, 0), 8'h00);
    bus(1'h1, ADDR_MODE, {6'h00, MODE_ENH1});
    bus(1'h1, ADDR_DIR, 8'he0);
    rdchk("dir", ADDR_DIR, 8'he0);
    $display("test reset done");
    bus(1'h1, ba(2, 0), 8'h40);
    seed = lfsr(seed);
    id0 = seed[28:0];
    rx(id0, 1'h1, 1'h1, 1'h1, 1'h1, {1'h0, seed[3:0]});
    rdchk("rx0 ctrl", ba(0, 0), {4'ha, seed[3:0]});
    rdchk("rx0 idh", ba(0, 1), idh(id0, 1'h1));
    rdchk("rx0 idl", ba(0, 2), idl(id0, 1'h1, 1'h1));
    rdchk("rx0 eidh", ba(0, 3), id0[15:8]);
    seed = lfsr(seed);
    id1 = {18'h00000, seed[10:0]};
    rx(id1, 1'h0, 1'h0, 1'h1, 1'h0, 5'h0f);
    rdchk("rx1 skipped", ba(1, 0), 8'h00);
    rdchk("rx2 ctrl", ba(2, 0), 8'hcf);
    rdchk("rx2 idl", ba(2, 2), idl(id1, 1'h0, 1'h1));
    seed = lfsr(seed);
    id2 = {18'h00000, seed[10:0]};
    rx(id2, 1'h0, 1'h0, 1'h0, 1'h1, 5'h00);
    rdchk("rx0 held", ba(0, 1), idh(id0, 1'h1));
    rdchk("rx1 ctrl", ba(1, 0), 8'h80);
    bus(1'h1, ba(0, 0), 8'h00);
    rdchk("rx0 cleared", ba(0, 0), {4'h2, id0[3:0]});
    bus(1'h1, ba(1, 1), 8'h55);
    rdchk("rx id locked", ba(1, 1), idh(id2, 1'h0));
    rdchk("unmapped", 9'h0fc, 8'h00);
    $display("test receive done");
    seed = lfsr(seed);
    {h4, eh, el, l4} = {seed[23:0], seed[31:29], 3'h2, seed[1:0]};
    bus(1'h1, ba(4, 1), h4);
    bus(1'h1, ba(4, 2), l4);
    bus(1'h1, ba(4, 3), eh);
    bus(1'h1, ba(4, 4), el);
    rdchk("tx idl", ba(4, 2), l4 & 8'hef);
    bus(1'h1, ba(3, 0), 8'h0a);
    bus(1'h1, ba(4, 0), 8'h0a);
    bus(1'h1, ba(5, 0), 8'h09);
    bus(1'h1, ba(4, 1), ~h4);
    rdchk("locked", ba(4, 1), h4);
    stall <= 1'h0;
    settle(3, 3);
    chk("order", 9'h11d, {took_idx[0], took_idx[1], took_idx[2]});
    chk("ext id", {1'h1, h4, l4[7:5], l4[1:0], eh, el}, took_id[0]);
    chk("std id", 32'h0, took_id[1]);
    rdchk("sent", ba(4, 0), 8'h82);
    $display("test priority done");
    outcome <= 2'h1;
    delay <= 4'hf;
    bus(1'h1, ba(3, 0), 8'h0a);
    for (int i = 0; i < 50 && took_idx.size() < 4; i++)
      @(posedge clk);
    bus(1'h1, ba(3, 0), 8'h02);
    settle(4, 4);
    rdchk("abort flight", ba(3, 0), 8'h62);
    stall <= 1'h1;
    bus(1'h1, ba(3, 0), 8'h0a);
    rdchk("flags cleared", ba(3, 0), 8'h0a);
    bus(1'h1, ba(3, 0), 8'h02);
    rdchk("abort idle", ba(3, 0), 8'h42);
    outcome <= 2'h2;
    stall <= 1'h0;
    bus(1'h1, ba(3, 0), 8'h0a);
    settle(6, 5);
    outcome <= 2'h0;
    rdchk("bus error", ba(3, 0), 8'h1a);
    settle(6, 6);
    rdchk("retried", ba(3, 0), 8'h92);
    $display("test outcome done");
    stall <= 1'h1;
    bus(1'h1, ba(5, 0), 8'h04);
    rx(29'h0, 1'h0, 1'h1, 1'h0, 1'h1, 5'h00);
    rdchk("auto reply", ba(5, 0), 8'h0c);
    rdchk("no reply", ba(3, 0), 8'h92);
    stall <= 1'h0;
    settle(7, 7);
    rdchk("reply sent", ba(5, 0), 8'h84);
    $display("test auto reply done");
    wrap_up();
  end
endmodule : cptb_buffers_bench
`default_nettype wire

// ===== testbench/cptb_checker.sv
`timescale 1ns/10ps
`default_nettype none
module cptb_checker
  import cptb_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic [cptb_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [cptb_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0]                  avs_byteenable,
  input wire logic [cptb_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        tx_frame_valid,
  input wire logic                        tx_frame_ready,
  input wire logic                        tx_abort_request,
  input wire logic                        tx_sent,
  input wire logic                        tx_lost_arb,
  input wire logic                        tx_bus_error
);
  logic [1:0] mode_reg;
  logic       busy_reg;
  logic       inert;
  logic       rd_done;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_reg <= MODE_LEGACY;
      busy_reg <= 1'h0;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == ADDR_MODE)
        mode_reg <= avs_writedata[1:0];
      if (tx_frame_valid && tx_frame_ready)
        busy_reg <= 1'h1;
      else if (tx_sent || tx_lost_arb || tx_bus_error)
        busy_reg <= 1'h0;
    end
  end
  assign inert   = (mode_reg != MODE_ENH1) && (mode_reg != MODE_ENH2);
  assign rd_done = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_BUS_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("idle wait");
  AST_LEGACY_QUIET: assert property (inert |-> !tx_frame_valid && !tx_abort_request)
    else $error("legacy traffic");
  AST_LEGACY_READ: assert property (inert && rd_done && avs_address[BUF_SEL_BIT] |-> avs_readdata == '0)
    else $error("legacy read");
  AST_TAKE_DROPS: assert property (tx_frame_valid && tx_frame_ready |-> ##1 !tx_frame_valid)
    else $error("offer held");
  AST_BUSY_NO_OFFER: assert property (busy_reg |-> !tx_frame_valid)
    else $error("busy offer");
  AST_SENT_GAP: assert property (busy_reg && tx_sent |=> !tx_frame_valid)
    else $error("offer right after send");
  AST_ABORT_FLIGHT: assert property (tx_abort_request |-> busy_reg || tx_frame_valid)
    else $error("stray abort");
  AST_IDL_GAP: assert property (rd_done && avs_address[BUF_SEL_BIT] && avs_address[4:2] == SUB_IDL
    |-> avs_readdata[2] == 1'h0 && avs_readdata[31:8] == '0)
    else $error("idl gap set");
  AST_DIR_LOW: assert property (rd_done && avs_address == ADDR_DIR |-> avs_readdata[1:0] == 2'h0)
    else $error("dir low set");
  COV_SENT: cover property (tx_sent);
  COV_LOST: cover property (tx_lost_arb);
  COV_ABORT: cover property (tx_abort_request);
endmodule : cptb_checker
bind cptb_buffers cptb_checker u_checker (.clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_frame_valid,
  .tx_frame_ready, .tx_abort_request, .tx_sent, .tx_lost_arb, .tx_bus_error);
`default_nettype wire

// ===== testbench/cptb_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module cptb_engine_model
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       tx_frame_valid,
  input  wire logic       stall,
  input  wire logic [1:0] outcome,
  input  wire logic [3:0] delay,
  output logic            tx_frame_ready,
  output logic            tx_sent,
  output logic            tx_lost_arb,
  output logic            tx_bus_error
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      busy_reg       <= 1'h0;
      cnt_reg        <= 4'h0;
      tx_frame_ready <= 1'h0;
      {tx_sent, tx_lost_arb, tx_bus_error} <= 3'h0;
    end
    else
    begin
      {tx_sent, tx_lost_arb, tx_bus_error} <= 3'h0;
      if (!busy_reg)
      begin
        tx_frame_ready <= stall ? 1'h0 : !(tx_frame_valid && tx_frame_ready);
        if (tx_frame_valid && tx_frame_ready)
        begin
          busy_reg <= 1'h1;
          cnt_reg  <= delay;
        end
      end
      else if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
      else
      begin
        busy_reg     <= 1'h0;
        tx_sent      <= outcome == 2'h0;
        tx_lost_arb  <= outcome == 2'h1;
        tx_bus_error <= outcome == 2'h2;
      end
    end
  end
endmodule : cptb_engine_model
`default_nettype wire
